// *** design/gpb_port.sv ***
// Eight-bit bidirectional port with direction register, AXI4-Lite slave
//
// Register access over AXI4-Lite was decided locally.
module gpb_port
(
  input  wire logic        aclk,          // 100 MHz clock
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [11:0] s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [11:0] s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  input  wire logic [7:0]  port_io_in,    // Pin levels
  output logic [7:0]       port_io_out,   // Pin drive values
  output logic [7:0]       port_io_oe     // Pin drive enables, high drives
);

  // Port state and instruction phase
  logic [7:0]        latch;
  logic [7:0]        next_latch;
  logic [7:0]        port_direction;
  logic [7:0]        next_port_direction;
  logic [1:0]        phase;
  logic [1:0]        next_phase;

  // Write channel state
  gpb_pkg::gpb_state_t wst;
  gpb_pkg::gpb_state_t next_wst;
  logic [11:0]       waddr;
  logic [11:0]       next_waddr;
  logic [31:0]       wdata;
  logic [31:0]       next_wdata;
  logic [3:0]        wstrb;
  logic [3:0]        next_wstrb;
  logic              have_aw;
  logic              next_have_aw;
  logic              have_w;
  logic              next_have_w;
  logic [7:0]        rmw_snap;
  logic [7:0]        next_rmw_snap;
  logic [1:0]        next_bresp;

  // Read channel state
  gpb_pkg::gpb_state_t rst;
  gpb_pkg::gpb_state_t next_rst;
  logic [11:0]       raddr;
  logic [11:0]       next_raddr;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // Next values of the registered outputs
  logic              next_s_awready;
  logic              next_s_wready;
  logic              next_s_bvalid;
  logic              next_s_arready;
  logic              next_s_rvalid;
  logic [7:0]        next_port_io_oe;
  logic [7:0]        next_port_io_out;

  // Free-running four-phase instruction cycle
  always_comb
  begin
    next_phase = phase + 2'h1;
  end

  // Write side: collect address and data, snapshot pins in phase two,
  // commit the written byte or the pin snapshot in phase four. On an unstrobed data write the
  // snapshot of input pins replaces their latch bits, so a pending value there is lost.
  always_comb
  begin
    next_wst            = wst;
    next_waddr          = waddr;
    next_wdata          = wdata;
    next_wstrb          = wstrb;
    next_have_aw        = have_aw;
    next_have_w         = have_w;
    next_rmw_snap       = rmw_snap;
    next_latch          = latch;
    next_port_direction = port_direction;
    next_bresp          = s_bresp;
    unique case (wst)
      gpb_pkg::GPB_IDLE:
      begin
        if (s_awvalid && !have_aw)
        begin
          next_waddr   = s_awaddr;
          next_have_aw = 1'b1;
        end
        if (s_wvalid && !have_w)
        begin
          next_wdata  = s_wdata;
          next_wstrb  = s_wstrb;
          next_have_w = 1'b1;
        end
        if (have_aw && have_w)
          next_wst = gpb_pkg::GPB_WAIT_RD;
      end
      gpb_pkg::GPB_WAIT_RD:
      begin
        if (phase == gpb_pkg::PH_TWO)
        begin
          next_rmw_snap = port_io_in;
          next_wst      = gpb_pkg::GPB_WAIT_WR;
        end
      end
      gpb_pkg::GPB_WAIT_WR:
      begin
        if (phase == gpb_pkg::PH_FOUR)
        begin
          next_bresp = gpb_pkg::RESP_OKAY;
          if (waddr == gpb_pkg::ADDR_DATA)
          begin
            // Unstrobed lane keeps the pin snapshot, so an unstrobed write
            // stores a full byte taken from the pins
            next_latch = wstrb[0] ? wdata[7:0] : rmw_snap;
          end
          else if (waddr == gpb_pkg::ADDR_DIR)
          begin
            if (wstrb[0])
              next_port_direction = wdata[7:0];
          end
          else
            next_bresp = gpb_pkg::RESP_SLVERR;
          next_wst = gpb_pkg::GPB_RESP;
        end
      end
      gpb_pkg::GPB_RESP:
      begin
        if (s_bready)
        begin
          next_have_aw = 1'b0;
          next_have_w  = 1'b0;
          next_wst     = gpb_pkg::GPB_IDLE;
        end
      end
    endcase
  end

  // Read side: pins are sampled in phase two of the cycle
  always_comb
  begin
    next_rst   = rst;
    next_raddr = raddr;
    next_rdata = s_rdata;
    next_rresp = s_rresp;
    unique case (rst)
      gpb_pkg::GPB_IDLE:
      begin
        if (s_arvalid)
        begin
          next_raddr = s_araddr;
          next_rst   = gpb_pkg::GPB_WAIT_RD;
        end
      end
      gpb_pkg::GPB_WAIT_RD:
      begin
        if (phase == gpb_pkg::PH_TWO)
        begin
          next_rresp = gpb_pkg::RESP_OKAY;
          next_rdata = 32'h0000_0000;
          if (raddr == gpb_pkg::ADDR_DATA)
            next_rdata[7:0] = port_io_in;
          else if (raddr == gpb_pkg::ADDR_DIR)
            next_rdata[7:0] = port_direction;
          else
            next_rresp = gpb_pkg::RESP_SLVERR;
          next_rst = gpb_pkg::GPB_RESP;
        end
      end
      gpb_pkg::GPB_WAIT_WR:
        next_rst = gpb_pkg::GPB_IDLE;
      gpb_pkg::GPB_RESP:
      begin
        if (s_rready)
          next_rst = gpb_pkg::GPB_IDLE;
      end
    endcase
  end

  // Handshake and pin outputs; each ready pulses once on its capture
  // edge so the master never sees a second handshake for one item
  always_comb
  begin
    next_s_awready   = (wst == gpb_pkg::GPB_IDLE) && s_awvalid && !have_aw
                       && !s_awready;
    next_s_wready    = (wst == gpb_pkg::GPB_IDLE) && s_wvalid && !have_w
                       && !s_wready;
    next_s_bvalid    = (next_wst == gpb_pkg::GPB_RESP);
    next_s_arready   = (rst == gpb_pkg::GPB_IDLE) && s_arvalid;
    next_s_rvalid    = (next_rst == gpb_pkg::GPB_RESP);
    // Pins take latch and direction on the same edge as the registers
    next_port_io_oe  = ~next_port_direction;
    next_port_io_out = next_latch;
  end

  // Registers; the latch has no reset since its power-up value is
  // undefined and a reset must not disturb it
  always_ff @(posedge aclk)
  begin
    latch    <= next_latch;
    rmw_snap <= next_rmw_snap;
    waddr    <= next_waddr;
    wdata    <= next_wdata;
    wstrb    <= next_wstrb;
    raddr    <= next_raddr;
    if (!aresetn)
    begin
      port_direction <= gpb_pkg::DIR_RESET;
      phase          <= gpb_pkg::PH_ONE;
      wst            <= gpb_pkg::GPB_IDLE;
      rst            <= gpb_pkg::GPB_IDLE;
      have_aw        <= 1'b0;
      have_w         <= 1'b0;
      s_awready      <= 1'b0;
      s_wready       <= 1'b0;
      s_bvalid       <= 1'b0;
      s_bresp        <= gpb_pkg::RESP_OKAY;
      s_arready      <= 1'b0;
      s_rvalid       <= 1'b0;
      s_rresp        <= gpb_pkg::RESP_OKAY;
      s_rdata        <= 32'h0000_0000;
      port_io_oe     <= 8'h00;
      port_io_out    <= 8'h00;
    end
    else
    begin
      port_direction <= next_port_direction;
      phase          <= next_phase;
      wst            <= next_wst;
      rst            <= next_rst;
      have_aw        <= next_have_aw;
      have_w         <= next_have_w;
      s_awready   <= next_s_awready;
      s_wready    <= next_s_wready;
      s_bvalid    <= next_s_bvalid;
      s_bresp     <= next_bresp;
      s_arready   <= next_s_arready;
      s_rvalid    <= next_s_rvalid;
      s_rresp     <= next_rresp;
      s_rdata     <= next_rdata;
      port_io_oe  <= next_port_io_oe;
      port_io_out <= next_port_io_out;
    end
  end

  // Pins are driven exactly where the direction bit is zero
  pin_drive_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    port_io_oe == ~port_direction)
    else $error("pin enable does not follow direction");
  // A data write shows the new latch on the pins at once; checked only
  // after a commit because the latch is unknown until first written
  pin_value_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_RESP && $past(wst) == gpb_pkg::GPB_WAIT_WR
    && waddr == gpb_pkg::ADDR_DATA |-> port_io_out == latch)
    else $error("pin value does not follow latch");
  // Data reads carry pin levels sampled in phase two
  read_pins_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rst == gpb_pkg::GPB_WAIT_RD && phase == gpb_pkg::PH_TWO
    && raddr == gpb_pkg::ADDR_DATA
    |=> s_rvalid && s_rdata == {24'h000000, $past(port_io_in)})
    else $error("data read did not return pin levels");
  // Write commit only in phase four
  write_phase_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $rose(s_bvalid) |-> $past(phase) == gpb_pkg::PH_FOUR)
    else $error("write committed outside phase four");
  // Data write with its lane-zero strobe stores the written byte
  latch_store_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_WAIT_WR && phase == gpb_pkg::PH_FOUR
    && waddr == gpb_pkg::ADDR_DATA && wstrb[0]
    |=> latch == $past(wdata[7:0]))
    else $error("latch did not take written byte");
  // Unstrobed data write restores the pin snapshot
  rmw_merge_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_WAIT_WR && phase == gpb_pkg::PH_FOUR
    && waddr == gpb_pkg::ADDR_DATA && !wstrb[0]
    |=> latch == $past(rmw_snap))
    else $error("latch lost pin snapshot");
  // Snapshot of the pins taken in phase two
  rmw_read_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_WAIT_RD && phase == gpb_pkg::PH_TWO
    |=> rmw_snap == $past(port_io_in) ##[1:2] s_bvalid)
    else $error("pin snapshot or response missing");
  // Reset leaves every pin an input
  dir_reset_a: assert property (@(posedge aclk)
    !aresetn |=> port_direction == gpb_pkg::DIR_RESET && port_io_oe == 8'h00)
    else $error("direction not all inputs after reset");
  // Direction register written only at its address
  dir_write_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    port_direction != $past(port_direction) && $past(aresetn)
    |-> $past(waddr) == gpb_pkg::ADDR_DIR)
    else $error("direction changed by wrong address");
  // Direction write without its lane strobe leaves every bit alone
  dir_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_WAIT_WR && phase == gpb_pkg::PH_FOUR
    && waddr == gpb_pkg::ADDR_DIR && !wstrb[0]
    |=> $stable(port_direction))
    else $error("direction changed by unstrobed write");
  // Writes outside the two registers are answered with an error
  addr_error_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wst == gpb_pkg::GPB_WAIT_WR && phase == gpb_pkg::PH_FOUR
    && waddr != gpb_pkg::ADDR_DATA && waddr != gpb_pkg::ADDR_DIR
    |=> s_bvalid && s_bresp == gpb_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule : gpb_port

// *** design/gpb_pkg.sv ***
// Package of constants for the bidirectional port block
// Notes on behaviour
// - An eight-bit output latch holds one data bit per port pin.
// - Each pin has its own direction bit selecting input or output.
// - Direction bit one leaves the pin driver in high impedance.
// - Direction bit zero drives the pin from its latch bit.
// - Reading the data register returns the pin levels, not the latch.
// - Writing the data register loads the latch whatever the direction.
// - Every write reads all pins, merges the change, writes the full byte; the code uses the snapshot only on an unstrobed data write.
// - Input pins overwrite their latch bits with sampled levels on write; the code does so only on an unstrobed data write.
// - Operand read falls in phase two, destination write in phase four.
package gpb_pkg;
  localparam int unsigned PORT_W      = 8;
  localparam logic [11:0] IDX_DATA    = 12'h007;
  localparam logic [11:0] IDX_DIR     = 12'h087;
  // Byte address is four times the register index
  localparam logic [11:0] ADDR_DATA   = IDX_DATA << 2;
  localparam logic [11:0] ADDR_DIR    = IDX_DIR << 2;
  localparam logic [7:0]  DIR_RESET   = 8'hff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  PH_ONE      = 2'h0;
  localparam logic [1:0]  PH_TWO      = 2'h1;
  localparam logic [1:0]  PH_FOUR     = 2'h3;
  typedef enum logic [1:0] {GPB_IDLE, GPB_WAIT_RD, GPB_WAIT_WR, GPB_RESP}
    gpb_state_t;
endpackage : gpb_pkg

// *** tb/gpb_pins.sv ***
// Model of the outside circuitry wired to the port pins
module gpb_pins
(
  input  wire logic [7:0] port_io_out, // Device drive values
  input  wire logic [7:0] port_io_oe,  // Device drive enables
  input  wire logic [7:0] ext_drive,   // Levels the outside circuit offers
  output logic      [7:0] pin_level    // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside circuit backs off wherever the device drives, so no contention
  always_comb
  begin
    for (int i = 0; i < gpb_pkg::PORT_W; i++)
      pin_level[i] = port_io_oe[i] ? port_io_out[i] : ext_drive[i];
  end
endmodule // gpb_pins

// *** tb/testbench.sv ***
// Self-checking bench for the bidirectional port block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  port_io_in, port_io_out, port_io_oe, ext_drive, lat, dir, snap;
  logic [9:0]  rd_q[$];
  logic [1:0]  wr_q[$];
  logic [9:0]  note;
  int          err_count, num_checks, seed;

  gpb_port i_gpb_port
  (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .port_io_in(port_io_in),
    .port_io_out(port_io_out), .port_io_oe(port_io_oe)
  );
  gpb_pins i_gpb_pins
  (
    .port_io_out(port_io_out), .port_io_oe(port_io_oe),
    .ext_drive(ext_drive), .pin_level(port_io_in)
  );

  // Free-running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    wr_q.push_back(er);
    s_awaddr <= a;
    s_wdata <= 32'(d);
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    rd_q.push_back({er, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Latch and enables reach the pins on the same edge that raises the response
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  // Monitor takes the oldest note whenever a response is handed over
  always @(posedge aclk)
  begin
    if (s_rvalid && s_rready)
    begin
      note = rd_q.pop_front();
      check("rdata", s_rdata, 32'(note[7:0]));
      check("rresp", 32'(s_rresp), 32'(note[9:8]));
    end
    if (s_bvalid && s_bready)
      check("bresp", 32'(s_bresp), 32'(wr_q.pop_front()));
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #100000;
    err_count++;
    report_and_stop;
  end

  initial
  begin
    seed = 49919;
    {err_count, num_checks} = '0;
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, ext_drive} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(gpb_pkg::ADDR_DIR, gpb_pkg::DIR_RESET, gpb_pkg::RESP_OKAY);
    check("oe after reset", 32'(port_io_oe), 32'h0);
    // Random directions, latch values and outside levels
    for (int i = 0; i < 8; i++)
    begin
      dir = 8'($random(seed));
      lat = 8'($random(seed));
      ext_drive <= 8'($random(seed));
      // Latch first, so no pin is ever driven from an unloaded latch
      wr(gpb_pkg::ADDR_DATA, lat, 4'h1, gpb_pkg::RESP_OKAY);
      wr(gpb_pkg::ADDR_DIR, dir, 4'h1, gpb_pkg::RESP_OKAY);
      settle;
      check("pin out", 32'(port_io_out), 32'(lat));
      check("pin oe", 32'(port_io_oe), {24'h000000, ~dir});
      rd(gpb_pkg::ADDR_DATA, (lat & ~dir) | (ext_drive & dir),
         gpb_pkg::RESP_OKAY);
    end
    // Write that modifies nothing: input pins overwrite their latch bits
    wr(gpb_pkg::ADDR_DIR, 8'h0f, 4'h1, gpb_pkg::RESP_OKAY);
    ext_drive <= 8'h3c;
    wr(gpb_pkg::ADDR_DATA, 8'h00, 4'h0, gpb_pkg::RESP_OKAY);
    snap = (lat & 8'hf0) | 8'h0c;
    wr(gpb_pkg::ADDR_DIR, 8'h00, 4'h1, gpb_pkg::RESP_OKAY);
    settle;
    check("rmw latch", 32'(port_io_out), 32'(snap));
    // Unmapped place is refused both ways
    wr(12'h100, 8'h55, 4'h1, gpb_pkg::RESP_SLVERR);
    rd(12'h100, 8'h00, gpb_pkg::RESP_SLVERR);
    // Second reset mid-run: directions return to input, latch survives
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(gpb_pkg::ADDR_DIR, gpb_pkg::DIR_RESET, gpb_pkg::RESP_OKAY);
    check("oe after reset", 32'(port_io_oe), 32'h0);
    // Unstrobed direction write must leave every pin an input
    wr(gpb_pkg::ADDR_DIR, 8'h00, 4'h0, gpb_pkg::RESP_OKAY);
    rd(gpb_pkg::ADDR_DIR, gpb_pkg::DIR_RESET, gpb_pkg::RESP_OKAY);
    wr(gpb_pkg::ADDR_DIR, 8'h00, 4'h1, gpb_pkg::RESP_OKAY);
    settle;
    check("latch kept", 32'(port_io_out), 32'(snap));
    report_and_stop;
  end
endmodule // testbench
